// >>> sfb_pkg.sv
package sfb_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_RATES  = 8'h09;
  localparam logic [7:0] IDX_MODE   = 8'h0A;
  localparam logic [7:0] IDX_CNT_HI = 8'h0B;
  localparam logic [7:0] IDX_CNT_LO = 8'h0C;
  localparam logic [7:0] IDX_PIN1   = 8'h0D;
  localparam logic [7:0] IDX_STATUS = 8'h3B;
  localparam logic [7:0] IDX_FUNC   = 8'h5E;
  localparam logic [7:0] REG_RST    = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int GY_LSB     = 4;
  localparam int XL_LSB     = 0;
  localparam int TS_LSB     = 6;
  localparam int TEMP_LSB   = 4;
  localparam int MODE_LSB   = 0;
  localparam int PULSED_BIT = 7;
  localparam int CLR_BIT    = 6;
  localparam int SRC_BIT    = 5;
  localparam int P1_STAMP   = 7;
  localparam int P1_CNT     = 6;
  localparam int P1_FULL    = 5;
  localparam int P1_OVR     = 4;
  localparam int P1_TH      = 3;
  localparam int P1_BOOT    = 2;
  localparam int P1_DRG     = 1;
  localparam int P1_DRX     = 0;
  localparam int ST_HIT     = 0;
  localparam int ST_DRX     = 1;
  localparam int ST_DRG     = 2;
  localparam int ST_DRS     = 3;
  localparam int ST_MODE    = 4;

  // ************************************************************
  // Codes
  // ************************************************************
  localparam logic [3:0] RATE_OFF  = 4'h0;
  localparam logic [3:0] RATE_MAX  = 4'hA;
  localparam logic [3:0] RATE_SLOW = 4'hB;
  localparam logic [2:0] MODE_BYP  = 3'h0;
  localparam logic [2:0] MODE_STOP = 3'h1;
  localparam logic [2:0] MODE_C2S  = 3'h3;
  localparam logic [2:0] MODE_B2C  = 3'h4;
  localparam logic [2:0] MODE_CONT = 3'h6;
  localparam logic [2:0] MODE_B2S  = 3'h7;
  localparam logic [1:0] TS_DIV1   = 2'h1;
  localparam logic [1:0] TS_DIV8   = 2'h2;
  localparam logic [4:0] TS_LAST1  = 5'h00;
  localparam logic [4:0] TS_LAST8  = 5'h07;
  localparam logic [4:0] TS_LAST32 = 5'h1F;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_NS    = 50;
  localparam int PULSE_NS  = 75000;
  localparam int PULSE_CYC = PULSE_NS / CLK_NS;

  typedef enum logic [2:0] {
    ST_BYPASS = 3'b001,
    ST_STOP   = 3'b010,
    ST_CONT   = 3'b100
  } sfb_state_t;

endpackage : sfb_pkg

// >>> sfb_top.sv
// Register access over AXI4-Lite is this design's own decision.
module sfb_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [9:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [9:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        accel_batch_evt,
  input  wire logic        gyro_batch_evt,
  input  wire logic        queue_full,
  input  wire logic        queue_overrun,
  input  wire logic        queue_threshold,
  input  wire logic        boot_status,
  input  wire logic        accel_ready_evt,
  input  wire logic        gyro_ready_evt,
  input  wire logic        stamped_ready_evt,
  input  wire logic        fifo_trigger,
  input  wire logic        i3c_addr_assigned,
  input  wire logic [7:0]  func_events,
  output logic [3:0]       gyro_batch_rate,
  output logic [3:0]       accel_batch_rate,
  output logic [1:0]       temperature_batch_rate,
  output logic             timestamp_batch,
  output logic             queue_store_en,
  output logic             queue_overwrite_en,
  output logic             first_interrupt_pin,
  output logic             ibi_request
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Orders rate codes by speed; the slow code 1011 ranks below codes 1 to A, above off
  function automatic logic [3:0] rate_rank(input logic [3:0] c);
    if (c == sfb_pkg::RATE_SLOW) begin
      rate_rank = 4'h1;
    end else if (c != sfb_pkg::RATE_OFF && c <= sfb_pkg::RATE_MAX) begin
      rate_rank = c + 4'h1;
    end else begin
      rate_rank = 4'h0;
    end
  endfunction : rate_rank

  function automatic logic idx_is(input logic [9:0] a,
                                  input logic [7:0] idx);
    idx_is = (a[9:2] == idx);
  endfunction : idx_is

  // ************************************************************
  // Register bus
  // ************************************************************
  logic [7:0]  rates_q, mode_q, cnt_hi_q, cnt_lo_q, pin1_q, func_q;
  logic [9:0]  aw_addr_q;
  logic [7:0]  w_data_q;
  logic        w_lane_q, aw_full_q, w_full_q;
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic        aw_take, w_take, wr_do, ar_take, rd_status;
  logic        wr_mode, wr_clr, hit_q;
  logic [2:0]  drdy_q;
  sfb_pkg::sfb_state_t state_q;

  assign aw_take   = awvalid && awready_q;
  assign w_take    = wvalid && wready_q;
  assign wr_do     = aw_full_q && w_full_q && !bvalid_q;
  assign ar_take   = arvalid && arready_q;
  assign rd_status = ar_take && idx_is(araddr, sfb_pkg::IDX_STATUS);
  assign wr_mode   = wr_do && w_lane_q
                     && idx_is(aw_addr_q, sfb_pkg::IDX_MODE);
  assign wr_clr    = wr_do && w_lane_q && w_data_q[sfb_pkg::CLR_BIT]
                     && idx_is(aw_addr_q, sfb_pkg::IDX_CNT_HI);

  // Address and data are taken in either order; one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= sfb_pkg::RESP_OK;
      aw_addr_q <= 10'h000;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
    end else if (ce) begin
      if (aw_take) begin
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_data_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end
      aw_full_q <= (aw_full_q || aw_take) && !wr_do;
      w_full_q  <= (w_full_q || w_take) && !wr_do;
      awready_q <= !(aw_full_q || aw_take) || wr_do;
      wready_q  <= !(w_full_q || w_take) || wr_do;
      if (wr_do) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (idx_is(aw_addr_q, sfb_pkg::IDX_RATES)
                  || idx_is(aw_addr_q, sfb_pkg::IDX_MODE)
                  || idx_is(aw_addr_q, sfb_pkg::IDX_CNT_HI)
                  || idx_is(aw_addr_q, sfb_pkg::IDX_CNT_LO)
                  || idx_is(aw_addr_q, sfb_pkg::IDX_PIN1)
                  || idx_is(aw_addr_q, sfb_pkg::IDX_STATUS)
                  || idx_is(aw_addr_q, sfb_pkg::IDX_FUNC))
                  ? sfb_pkg::RESP_OK : sfb_pkg::RESP_ERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Configuration registers; the clear bit is never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rates_q  <= sfb_pkg::REG_RST;
      mode_q   <= sfb_pkg::REG_RST;
      cnt_hi_q <= sfb_pkg::REG_RST;
      cnt_lo_q <= sfb_pkg::REG_RST;
      pin1_q   <= sfb_pkg::REG_RST;
      func_q   <= sfb_pkg::REG_RST;
    end else if (ce && wr_do && w_lane_q) begin
      case (aw_addr_q[9:2])
        sfb_pkg::IDX_RATES:  rates_q  <= w_data_q;
        sfb_pkg::IDX_MODE:   mode_q   <= {w_data_q[7:4], 1'b0,
                                          w_data_q[2:0]};
        sfb_pkg::IDX_CNT_HI: cnt_hi_q <= {w_data_q[7], 1'b0,
                                          w_data_q[5], 2'b00,
                                          w_data_q[2:0]};
        sfb_pkg::IDX_CNT_LO: cnt_lo_q <= w_data_q;
        sfb_pkg::IDX_PIN1:   pin1_q   <= w_data_q;
        sfb_pkg::IDX_FUNC:   func_q   <= w_data_q;
        default: ;
      endcase
    end
  end

  // Reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= sfb_pkg::RESP_OK;
    end else if (ce) begin
      if (ar_take) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= sfb_pkg::RESP_OK;
        case (araddr[9:2])
          sfb_pkg::IDX_RATES:  rdata_q <= {24'h000000, rates_q};
          sfb_pkg::IDX_MODE:   rdata_q <= {24'h000000, mode_q};
          sfb_pkg::IDX_CNT_HI: rdata_q <= {24'h000000, cnt_hi_q};
          sfb_pkg::IDX_CNT_LO: rdata_q <= {24'h000000, cnt_lo_q};
          sfb_pkg::IDX_PIN1:   rdata_q <= {24'h000000, pin1_q};
          sfb_pkg::IDX_FUNC:   rdata_q <= {24'h000000, func_q};
          sfb_pkg::IDX_STATUS: rdata_q <= {25'h0, state_q,
                                           drdy_q, hit_q};
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= sfb_pkg::RESP_ERR;
          end
        endcase
      end else if (rvalid_q && rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Queue mode sequencing
  // ************************************************************
  // The trigger phase re-arms on every mode write and ends on the
  // trigger's falling edge, so a stale release is never replayed
  logic armed_q, trig_q;
  logic [2:0] mode;
  assign mode = mode_q[sfb_pkg::MODE_LSB +: 3];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b1;
      trig_q  <= 1'b0;
    end else if (ce) begin
      trig_q <= fifo_trigger;
      if (wr_mode) begin
        armed_q <= 1'b1;
      end else if (trig_q && !fifo_trigger) begin
        armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= sfb_pkg::ST_BYPASS;
    end else if (ce) begin
      case (mode)
        sfb_pkg::MODE_BYP:  state_q <= sfb_pkg::ST_BYPASS;
        sfb_pkg::MODE_STOP: state_q <= sfb_pkg::ST_STOP;
        sfb_pkg::MODE_CONT: state_q <= sfb_pkg::ST_CONT;
        sfb_pkg::MODE_C2S:  state_q <= armed_q ? sfb_pkg::ST_CONT
                                               : sfb_pkg::ST_STOP;
        sfb_pkg::MODE_B2C:  state_q <= armed_q ? sfb_pkg::ST_BYPASS
                                               : sfb_pkg::ST_CONT;
        sfb_pkg::MODE_B2S:  state_q <= armed_q ? sfb_pkg::ST_BYPASS
                                               : sfb_pkg::ST_STOP;
        default:            state_q <= sfb_pkg::ST_BYPASS;
      endcase
    end
  end

  logic store_q, ovw_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_q <= 1'b0;
      ovw_q   <= 1'b0;
    end else if (ce) begin
      store_q <= (state_q == sfb_pkg::ST_CONT)
              || (state_q == sfb_pkg::ST_STOP && !queue_full);
      ovw_q   <= (state_q == sfb_pkg::ST_CONT);
    end
  end

  // ************************************************************
  // Timestamp decimation
  // ************************************************************
  logic [3:0] gy_rate, xl_rate;
  logic [1:0] ts_code;
  logic [4:0] ts_cnt_q, ts_last;
  logic       ts_q, ts_evt;
  assign gy_rate = rates_q[sfb_pkg::GY_LSB +: 4];
  assign xl_rate = rates_q[sfb_pkg::XL_LSB +: 4];
  assign ts_code = mode_q[sfb_pkg::TS_LSB +: 2];
  assign ts_evt  = (rate_rank(gy_rate) >= rate_rank(xl_rate))
                   ? gyro_batch_evt : accel_batch_evt;
  assign ts_last = (ts_code == sfb_pkg::TS_DIV1) ? sfb_pkg::TS_LAST1
                 : (ts_code == sfb_pkg::TS_DIV8) ? sfb_pkg::TS_LAST8
                 : sfb_pkg::TS_LAST32;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ts_cnt_q <= 5'h00;
      ts_q     <= 1'b0;
    end else if (ce) begin
      ts_q <= 1'b0;
      if (ts_code == 2'h0) begin
        ts_cnt_q <= 5'h00;
      end else if (ts_evt) begin
        ts_q     <= (ts_cnt_q >= ts_last);
        ts_cnt_q <= (ts_cnt_q >= ts_last) ? 5'h00 : ts_cnt_q + 5'h01;
      end
    end
  end

  // ************************************************************
  // Batching-event counter
  // ************************************************************
  logic [10:0] ev_cnt_q, ev_th;
  logic        ev_in;
  assign ev_th = {cnt_hi_q[2:0], cnt_lo_q};
  assign ev_in = cnt_hi_q[sfb_pkg::SRC_BIT] ? gyro_batch_evt
                                            : accel_batch_evt;

  // A zero threshold never fires; the flag's set beats a read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_cnt_q <= 11'h000;
      hit_q    <= 1'b0;
    end else if (ce) begin
      if (wr_clr) begin
        ev_cnt_q <= 11'h000;
      end else if (ev_in) begin
        if (ev_th != 11'h000 && ev_cnt_q + 11'h001 == ev_th) begin
          ev_cnt_q <= 11'h000;
        end else begin
          ev_cnt_q <= ev_cnt_q + 11'h001;
        end
      end
      if (!wr_clr && ev_in && ev_th != 11'h000
          && ev_cnt_q + 11'h001 == ev_th) begin
        hit_q <= 1'b1;
      end else if (rd_status) begin
        hit_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Data-ready styling
  // ************************************************************
  localparam logic [10:0] PULSE_LAST = 11'(sfb_pkg::PULSE_CYC - 1);
  logic [2:0]  dr_evt;
  logic [10:0] pcnt_q [3];
  assign dr_evt = {stamped_ready_evt, gyro_ready_evt, accel_ready_evt};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drdy_q <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        pcnt_q[i] <= 11'h000;
      end
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        if (cnt_hi_q[sfb_pkg::PULSED_BIT]) begin
          if (dr_evt[i]) begin
            drdy_q[i] <= 1'b1;
            pcnt_q[i] <= PULSE_LAST;
          end else if (pcnt_q[i] != 11'h000) begin
            pcnt_q[i] <= pcnt_q[i] - 11'h001;
          end else begin
            drdy_q[i] <= 1'b0;
          end
        end else begin
          pcnt_q[i] <= 11'h000;
          if (dr_evt[i]) begin
            drdy_q[i] <= 1'b1;
          end else if (rd_status) begin
            drdy_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  // ************************************************************
  // Interrupt routing
  // ************************************************************
  logic pin_q, ibi_q, pin_src, ibi_src;
  assign pin_src = (pin1_q[sfb_pkg::P1_STAMP] && drdy_q[2])
                || (pin1_q[sfb_pkg::P1_CNT]  && hit_q)
                || (pin1_q[sfb_pkg::P1_FULL] && queue_full)
                || (pin1_q[sfb_pkg::P1_OVR]  && queue_overrun)
                || (pin1_q[sfb_pkg::P1_TH]   && queue_threshold)
                || (pin1_q[sfb_pkg::P1_BOOT] && boot_status)
                || (pin1_q[sfb_pkg::P1_DRG]  && drdy_q[1])
                || (pin1_q[sfb_pkg::P1_DRX]  && drdy_q[0])
                || |(func_q & func_events);
  assign ibi_src = (pin1_q[sfb_pkg::P1_FULL] && queue_full)
                || (pin1_q[sfb_pkg::P1_OVR]  && queue_overrun)
                || (pin1_q[sfb_pkg::P1_TH]   && queue_threshold)
                || (pin1_q[sfb_pkg::P1_DRG]  && drdy_q[1])
                || (pin1_q[sfb_pkg::P1_DRX]  && drdy_q[0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
      ibi_q <= 1'b0;
    end else if (ce) begin
      pin_q <= !i3c_addr_assigned && pin_src;
      ibi_q <= i3c_addr_assigned && ibi_src;
    end
  end

  assign awready                = awready_q;
  assign wready                 = wready_q;
  assign bvalid                 = bvalid_q;
  assign bresp                  = bresp_q;
  assign arready                = arready_q;
  assign rvalid                 = rvalid_q;
  assign rdata                  = rdata_q;
  assign rresp                  = rresp_q;
  assign gyro_batch_rate        = gy_rate;
  assign accel_batch_rate       = xl_rate;
  assign temperature_batch_rate = mode_q[sfb_pkg::TEMP_LSB +: 2];
  assign timestamp_batch        = ts_q;
  assign queue_store_en         = store_q;
  assign queue_overwrite_en     = ovw_q;
  assign first_interrupt_pin    = pin_q;
  assign ibi_request            = ibi_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_BYPASS: assert property (ce && mode == sfb_pkg::MODE_BYP
    ##1 ce |-> state_q == sfb_pkg::ST_BYPASS ##1 !store_q)
    else $error("bypass mode still stores");
  AST_STOP_FULL: assert property (
    ce && state_q == sfb_pkg::ST_STOP && queue_full |=> !store_q)
    else $error("stop mode stored while full");
  AST_CONT_OVW: assert property (
    ce && state_q == sfb_pkg::ST_CONT |=> ovw_q && store_q)
    else $error("continuous mode not overwriting");
  AST_C2S_SWITCH: assert property (
    ce && mode == sfb_pkg::MODE_C2S && !wr_mode && trig_q
    && !fifo_trigger ##1 ce |=> state_q == sfb_pkg::ST_STOP)
    else $error("trigger release did not reach stop mode");
  AST_B2C_HOLD: assert property (
    ce && mode == sfb_pkg::MODE_B2C && armed_q
    |=> state_q == sfb_pkg::ST_BYPASS)
    else $error("left bypass before trigger release");
  AST_CNT_CLR: assert property (
    ce && wr_clr |=> ev_cnt_q == 11'h000 && !cnt_hi_q[sfb_pkg::CLR_BIT])
    else $error("counter clear ignored");
  AST_HIT: assert property ($rose(hit_q) |->
    $past(ev_cnt_q) + 11'h001 == ev_th && ev_cnt_q == 11'h000)
    else $error("hit flag without threshold match");
  AST_LATCH: assert property (
    ce && !cnt_hi_q[sfb_pkg::PULSED_BIT] && drdy_q[1] && !rd_status
    |=> drdy_q[1])
    else $error("latched data-ready dropped without read");
  AST_PULSE_LEN: assert property (
    ce && cnt_hi_q[sfb_pkg::PULSED_BIT] && dr_evt[0]
    |=> drdy_q[0] && pcnt_q[0] == PULSE_LAST)
    else $error("pulse did not start at full width");
  AST_PIN_I3C: assert property (
    ce && i3c_addr_assigned |=> !first_interrupt_pin)
    else $error("pin driven with dynamic address");
  AST_IBI: assert property (
    ce && i3c_addr_assigned && pin1_q[sfb_pkg::P1_FULL] && queue_full
    |=> ibi_request)
    else $error("full event gave no in-band interrupt");

endmodule : sfb_top

// >>> sfb_evt_src.sv
module sfb_evt_src (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [3:0] n_req,
  output logic            evt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_q = 4'h0;
  initial evt = 1'b0;
  // Batching events come as single-cycle pulses with a gap between them
  always @(posedge aclk) begin
    if (go) begin
      left_q <= n_req;
      evt    <= 1'b0;
    end else if (left_q != 4'h0 && !evt) begin
      left_q <= left_q - 4'h1;
      evt    <= 1'b1;
    end else begin
      evt <= 1'b0;
    end
  end
endmodule : sfb_evt_src

// >>> tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, go = 1'b0, use_gyro = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, fifo_trigger = 1'b0;
  logic i3c_addr_assigned = 1'b0;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF, n_req = 4'h0, lv = 4'h0;
  logic [2:0] rdy = 3'h0;
  logic [7:0] func_events = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, timestamp_batch, evt;
  logic queue_store_en, queue_overwrite_en, first_interrupt_pin, ibi_request;
  logic [1:0] bresp, rresp, temperature_batch_rate;
  logic [3:0] gyro_batch_rate, accel_batch_rate;
  logic accel_batch_evt, gyro_batch_evt, queue_full, queue_overrun;
  logic queue_threshold, boot_status;
  logic accel_ready_evt, gyro_ready_evt, stamped_ready_evt;
  logic [2:0] md [6] = '{3'h1, 3'h6, 3'h3, 3'h4, 3'h7, 3'h0};
  logic [3:0] ex [6] = '{4'hA, 4'hF, 4'hE, 4'h3, 4'h2, 4'h0};
  int errors = 0, cmp_count = 0, ts_n = 0;
  assign accel_batch_evt = evt & !use_gyro;
  assign gyro_batch_evt  = evt & use_gyro;
  assign {queue_full, queue_overrun, queue_threshold, boot_status} = lv;
  assign {stamped_ready_evt, gyro_ready_evt, accel_ready_evt} = rdy;
  always #25 aclk = ~aclk;
  always @(posedge aclk) if (timestamp_batch === 1'b1) ts_n++;
  sfb_top u_sfb_top (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .accel_batch_evt,
    .gyro_batch_evt, .queue_full, .queue_overrun, .queue_threshold,
    .boot_status, .accel_ready_evt, .gyro_ready_evt, .stamped_ready_evt,
    .fifo_trigger, .i3c_addr_assigned, .func_events, .gyro_batch_rate,
    .accel_batch_rate, .temperature_batch_rate, .timestamp_batch,
    .queue_store_en, .queue_overwrite_en, .first_interrupt_pin, .ibi_request);
  sfb_evt_src u_sfb_evt_src (.aclk, .go, .n_req, .evt);
  task automatic conclude;
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    logic a, w, b;
    a = 1'b1;
    w = 1'b1;
    b = 1'b1;
    awaddr  <= {idx, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 60 && b; n++) begin
      @(posedge aclk);
      if (a && awready) awvalid <= 1'b0;
      if (w && wready) wvalid <= 1'b0;
      a = a && !awready;
      w = w && !wready;
      if (bvalid) begin
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        b = 1'b0;
      end
    end
    // One spare edge so the next call never re-raises bready at once
    @(posedge aclk);
    if (b) begin
      errors++;
      conclude();
    end
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                    input logic [1:0] er);
    logic a, r;
    a = 1'b1;
    r = 1'b1;
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 60 && r; n++) begin
      @(posedge aclk);
      if (a && arready) arvalid <= 1'b0;
      a = a && !arready;
      if (rvalid) begin
        chk(rdata, {24'h0, exp});
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        r = 1'b0;
      end
    end
    @(posedge aclk);
    if (r) begin
      errors++;
      conclude();
    end
  endtask : rd
  task automatic pins(input logic [1:0] exp);
    repeat (3) @(posedge aclk);
    chk({30'h0, first_interrupt_pin, ibi_request}, {30'h0, exp});
  endtask : pins
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(sfb_pkg::IDX_RATES, 8'h00, sfb_pkg::RESP_OK);
    wr(sfb_pkg::IDX_RATES, 8'hBA, sfb_pkg::RESP_OK);
    chk({gyro_batch_rate, accel_batch_rate}, 32'hBA);
    wr(8'h20, 8'h55, sfb_pkg::RESP_ERR);
    rd(8'h20, 8'h00, sfb_pkg::RESP_ERR);
    for (int i = 0; i < 6; i++) begin
      fifo_trigger <= 1'b1;
      wr(sfb_pkg::IDX_MODE, {2'h0, i[1:0], 1'b0, md[i]}, sfb_pkg::RESP_OK);
      repeat (3) @(posedge aclk);
      chk(temperature_batch_rate, i[1:0]);
      chk({queue_store_en, queue_overwrite_en}, ex[i][3:2]);
      fifo_trigger <= 1'b0;
      // Release reaches the outputs three edges later
      repeat (4) @(posedge aclk);
      chk({queue_store_en, queue_overwrite_en}, ex[i][1:0]);
    end
    wr(sfb_pkg::IDX_CNT_LO, 8'h03, sfb_pkg::RESP_OK);
    wr(sfb_pkg::IDX_CNT_HI, 8'h40, sfb_pkg::RESP_OK);
    rd(sfb_pkg::IDX_CNT_HI, 8'h00, sfb_pkg::RESP_OK);
    use_gyro <= 1'b1;
    n_req <= 4'h6;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (20) @(posedge aclk);
    rd(sfb_pkg::IDX_STATUS, 8'h10, sfb_pkg::RESP_OK);
    wr(sfb_pkg::IDX_MODE, 8'h80, sfb_pkg::RESP_OK);
    ts_n = 0;
    use_gyro <= 1'b0;
    n_req <= 4'h8;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (24) @(posedge aclk);
    chk(ts_n, 1);
    rd(sfb_pkg::IDX_STATUS, 8'h11, sfb_pkg::RESP_OK);
    rd(sfb_pkg::IDX_STATUS, 8'h10, sfb_pkg::RESP_OK);
    wr(sfb_pkg::IDX_CNT_HI, 8'h60, sfb_pkg::RESP_OK);
    use_gyro <= 1'b1;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (24) @(posedge aclk);
    rd(sfb_pkg::IDX_STATUS, 8'h11, sfb_pkg::RESP_OK);
    wr(sfb_pkg::IDX_PIN1, 8'hFF, sfb_pkg::RESP_OK);
    for (int j = 0; j < 4; j++) begin
      lv <= 4'h1 << j;
      pins(2'b10);
      i3c_addr_assigned <= 1'b1;
      pins({1'b0, j != 0});
      i3c_addr_assigned <= 1'b0;
      lv <= 4'h0;
      pins(2'b00);
    end
    for (int j = 0; j < 3; j++) begin
      rdy <= 3'h1 << j;
      @(posedge aclk);
      rdy <= 3'h0;
      repeat (40) @(posedge aclk);
      pins(2'b10);
      rd(sfb_pkg::IDX_STATUS, 8'h10 | (8'h2 << j), sfb_pkg::RESP_OK);
      pins(2'b00);
    end
    wr(sfb_pkg::IDX_PIN1, 8'h00, sfb_pkg::RESP_OK);
    wr(sfb_pkg::IDX_FUNC, 8'h01, sfb_pkg::RESP_OK);
    lv <= 4'h8;
    func_events <= 8'h01;
    pins(2'b10);
    func_events <= 8'h00;
    pins(2'b00);
    lv <= 4'h0;
    wr(sfb_pkg::IDX_PIN1, 8'h01, sfb_pkg::RESP_OK);
    wr(sfb_pkg::IDX_CNT_HI, 8'h80, sfb_pkg::RESP_OK);
    rdy <= 3'h1;
    @(posedge aclk);
    rdy <= 3'h0;
    repeat (1400) @(posedge aclk);
    chk(first_interrupt_pin, 1'b1);
    // A low enable freezes the pulse counter, so the pulse stretches
    ce <= 1'b0;
    repeat (200) @(posedge aclk);
    chk(first_interrupt_pin, 1'b1);
    ce <= 1'b1;
    repeat (150) @(posedge aclk);
    chk(first_interrupt_pin, 1'b0);
    conclude();
  end
endmodule : tb
